/* design/hwr_pkg.sv */
// Purpose: constants and types for the halt, wake-up and reset controller
// Assumes: 32-bit APB, word-aligned registers
// Notes:   register offsets are byte addresses
package hwr_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] HWR_OFF_WDSEL   = 8'h00;
  localparam logic [7:0] HWR_OFF_STATUS  = 8'h04;
  localparam logic [7:0] HWR_OFF_INTERRUPT_CONTROL    = 8'h08;
  localparam logic [7:0] HWR_OFF_T0C     = 8'h0C;
  localparam logic [7:0] HWR_OFF_T1C     = 8'h10;
  localparam logic [7:0] HWR_OFF_PAD     = 8'h14;
  localparam logic [7:0] HWR_OFF_PADIR   = 8'h18;
  localparam logic [7:0] HWR_OFF_PBD     = 8'h1C;
  localparam logic [7:0] HWR_OFF_PBDIR   = 8'h20;
  localparam logic [7:0] HWR_OFF_PFD     = 8'h24;
  localparam logic [7:0] HWR_OFF_DACC    = 8'h28;
  localparam logic [7:0] HWR_OFF_CHSEL   = 8'h2C;
  localparam logic [7:0] HWR_OFF_CMD     = 8'h30;
  localparam logic [7:0] HWR_OFF_CPU     = 8'h34;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] HWR_RST_WDSEL = 8'h07;
  localparam logic [7:0] HWR_RST_INTERRUPT_CONTROL  = 8'h00;
  localparam logic [7:0] HWR_RST_TC    = 8'h08;
  localparam logic [7:0] HWR_RST_PORT  = 8'hFF;
  localparam logic [1:0] HWR_RST_2B    = 2'h0;
  localparam logic [3:0] HWR_RST_CHSEL = 4'h0;
  localparam logic [7:0] HWR_INTERRUPT_CONTROL_MASK = 8'h6D;
  localparam int         HWR_TC_FORCE  = 3;

  // interrupt_control fields
  localparam int HWR_INTERRUPT_CONTROL_EMI = 0;
  localparam int HWR_INTERRUPT_CONTROL_E0  = 2;
  localparam int HWR_INTERRUPT_CONTROL_E1  = 3;
  localparam int HWR_INTERRUPT_CONTROL_F0  = 5;
  localparam int HWR_INTERRUPT_CONTROL_F1  = 6;

  // status fields: bit 5 timeout, bit 4 powerdown
  localparam int HWR_ST_TO  = 5;
  localparam int HWR_ST_PD  = 4;

  // command register bits (write one to act)
  localparam int HWR_CMD_HALT = 0;
  localparam int HWR_CMD_CLRW = 1;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int HWR_STARTUP_TSYS = 1024;
  localparam int HWR_WAKE_EXTRA   = 1;

  typedef enum logic [3:0] {
    HWR_RUN   = 4'b0001,
    HWR_HALT  = 4'b0010,
    HWR_DELAY = 4'b0100,
    HWR_IACK  = 4'b1000
  } hwr_state_t;

  typedef enum logic [1:0] {
    HWR_RESUME_NEXT = 2'd0,
    HWR_RESUME_IRQ  = 2'd1,
    HWR_RESUME_WARM = 2'd2,
    HWR_RESUME_COLD = 2'd3
  } hwr_resume_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } hwr_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } hwr_apb_rsp_t;

endpackage

/* design/hwr_ctrl.sv */
// Purpose: halt mode, wake-up, start-up delay and reset-cause control
// Assumes: pclk is the system clock; cpu_stop_o gates it while halted
// Notes:   the watchdog counter itself lives outside; wdt_* ports talk to it
//
// Contract
// R1 - halt stops system clock, watchdog keeps running
// R2 - state and ports frozen during halt
// R3 - halt clears watchdog and its prescaler
// R4 - halt sets powerdown, clears timeout flag
// R5 - halt output high while halted
// R6 - wake on reset, irq, port edge, watchdog
// R7 - powerdown flag cleared power-up and clear-watchdog
// R8 - watchdog wake zeroes only pc and sp
// R9 - per-bit port a wake enable option
// R10 - port wake resumes at next instruction
// R11 - irq wake vectors only if enabled, stack free
// R12 - 1024-cycle dummy period after every wake-up; a pin reset wake goes straight to run with no delay
// R13 - interrupt entry one extra cycle later
// R14 - flag pending at halt cannot wake
// R15 - timeout and powerdown encode reset cause
// R16 - start-up delay on power-up and wake, not pin
// R17 - chip reset: pc zero, irq off, ports input
// R18 - full reset loads documented register values
// R19 - warm reset keeps registers, forces timer bit3
// R20 - watchdog overflow in run: chip reset, timeout
// R21 - delay counter on restarted clock, full count
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module hwr_ctrl
  import hwr_pkg::*;
#(
  parameter int          STARTUP_CYCLES = HWR_STARTUP_TSYS,
  parameter logic [7:0]  PA_WAKE_OPTION = 8'hFF
)(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire hwr_apb_req_t apb_req,
  output hwr_apb_rsp_t      apb_rsp,
  input  wire logic         external_reset_pin_n,
  input  wire logic [7:0]   port_a_pins,
  input  wire logic         wdt_overflow,
  input  wire logic [1:0]   irq_event,
  input  wire logic         stack_full,
  output logic              wdt_clear,
  output logic              halt_out,
  output logic              cpu_stop_o,
  output logic              pc_sp_reset,
  output logic              chip_reset,
  output logic              irq_vector_req,
  output logic [7:0]        port_a_oe,
  output logic [7:0]        port_b_oe
);

  // ---------------------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------------------
  localparam int CW = $clog2(STARTUP_CYCLES + HWR_WAKE_EXTRA + 1);
  if (STARTUP_CYCLES < 1)
  begin : g_bad
    $error("startup cycles must be at least one");
  end

  if (HWR_TC_FORCE > 7 || HWR_INTERRUPT_CONTROL_F1 > 7)
  begin : g_bad_field
    $error("register field outside the 8-bit registers");
  end

  localparam logic [CW-1:0] DLY_LAST = CW'(STARTUP_CYCLES - 1);

  hwr_state_t    state_q;
  hwr_resume_t   resume_q;
  logic [CW-1:0] dly_q;
  logic [7:0]    wdsel_q;
  logic [5:0]    status_q;
  logic [7:0]    interrupt_control_q;
  logic [7:0]    t0c_q;
  logic [7:0]    t1c_q;
  logic [7:0]    pad_q;
  logic [7:0]    padir_q;
  logic [7:0]    pbd_q;
  logic [7:0]    pbdir_q;
  logic [1:0]    pfd_q;
  logic [1:0]    dacc_q;
  logic [3:0]    chsel_q;
  logic [7:0]    pa_prev_q;
  logic [1:0]    irq_block_q;
  logic          pin_prev_q;
  logic          halt_cmd;
  logic          clrw_cmd;
  logic          wr;
  logic          rd;
  logic          pin_fall;
  logic          pa_wake;
  logic          irq_wake;
  logic          wdt_wake;
  logic          wake;
  logic          wdt_run_rst;
  logic          full_rst;
  logic          irq_en_any;
  logic          halted;

  function automatic logic hit(input logic [7:0] off);
    return apb_req.paddr == off;
  endfunction

  // ---------------------------------------------------------------------------
  // interrupt flags
  // ---------------------------------------------------------------------------
  // a timer request that lands with a software write of the control
  // register is kept: the hardware set wins
  function automatic logic [7:0] set_irq_flags(input logic [7:0] cur, input logic [1:0] evt);
    logic [7:0] res;
    res              = cur;
    res[HWR_INTERRUPT_CONTROL_F0] = cur[HWR_INTERRUPT_CONTROL_F0] | evt[0];
    res[HWR_INTERRUPT_CONTROL_F1] = cur[HWR_INTERRUPT_CONTROL_F1] | evt[1];
    return res;
  endfunction

  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd = apb_req.psel & ~apb_req.pwrite;
  assign halt_cmd = wr & hit(HWR_OFF_CMD) & apb_req.pwdata[HWR_CMD_HALT] & (state_q == HWR_RUN);
  assign clrw_cmd = wr & hit(HWR_OFF_CMD) & apb_req.pwdata[HWR_CMD_CLRW];
  assign halted   = (state_q == HWR_HALT);

  // ---------------------------------------------------------------------------
  // wake sources
  // ---------------------------------------------------------------------------
  assign pin_fall = pin_prev_q & ~external_reset_pin_n;
  assign pa_wake  = |(pa_prev_q & ~port_a_pins & PA_WAKE_OPTION); // R9
  assign irq_wake = |(irq_event & ~irq_block_q);                   // R14
  assign wdt_wake = halted & wdt_overflow;
  assign wake     = halted & (pa_wake | irq_wake | wdt_overflow);  // R6
  assign wdt_run_rst = (state_q != HWR_HALT) & wdt_overflow;       // R20
  // pin reset, either state, and run-time watchdog reset re-initialise
  assign full_rst = pin_fall | wdt_run_rst;                        // R17
  assign irq_en_any = interrupt_control_q[HWR_INTERRUPT_CONTROL_EMI] &
                      ((irq_event[0] & interrupt_control_q[HWR_INTERRUPT_CONTROL_E0]) | (irq_event[1] & interrupt_control_q[HWR_INTERRUPT_CONTROL_E1]));

  // ---------------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q  <= HWR_DELAY;            // R16
      resume_q <= HWR_RESUME_COLD;
      dly_q    <= '0;
    end
    // a pin reset overrides every state and skips the start-up delay
    else if (pin_fall)
    begin
      state_q  <= HWR_RUN;              // R16
      resume_q <= HWR_RESUME_COLD;
      dly_q    <= '0;
    end
    else
    begin
      case (state_q)
        HWR_RUN:
        begin
          if (halt_cmd)
            state_q <= HWR_HALT;        // R1
        end
        HWR_HALT:
        begin
          if (wake)
          begin
            state_q <= HWR_DELAY;       // R12
            dly_q   <= '0;
            if (wdt_wake)
              resume_q <= HWR_RESUME_WARM;                      // R8
            else if (irq_wake & irq_en_any & ~stack_full)
              resume_q <= HWR_RESUME_IRQ;                       // R11
            else
              resume_q <= HWR_RESUME_NEXT;                      // R10
          end
        end
        HWR_DELAY:
        begin
          dly_q <= dly_q + CW'(1);                              // R21
          if (dly_q == DLY_LAST)
          begin
            dly_q   <= '0;
            state_q <= (resume_q == HWR_RESUME_IRQ) ? HWR_IACK : HWR_RUN; // R12
          end
        end
        HWR_IACK:
          state_q <= HWR_RUN;                                   // R13
        default:
          state_q <= HWR_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // edge history and halt-entry irq snapshot
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // idle-high history, so no false edge follows reset
      pin_prev_q  <= 1'b1;
      pa_prev_q   <= HWR_RST_PORT;
      irq_block_q <= '0;
    end
    else
    begin
      pin_prev_q <= external_reset_pin_n;
      pa_prev_q  <= port_a_pins;
      if (halt_cmd)
        irq_block_q <= {interrupt_control_q[HWR_INTERRUPT_CONTROL_F1], interrupt_control_q[HWR_INTERRUPT_CONTROL_F0]}; // R14
    end
  end

  // ---------------------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= '0;                                           // R15
    else
    begin
      if (wr & hit(HWR_OFF_STATUS))
        status_q[3:0] <= apb_req.pwdata[3:0];
      // events take priority over the clear-watchdog command
      if (halt_cmd)
      begin
        status_q[HWR_ST_PD] <= 1'b1;                            // R4
        status_q[HWR_ST_TO] <= 1'b0;                            // R4
      end
      else if (wdt_wake)
      begin
        status_q[HWR_ST_TO] <= 1'b1;                            // R15
        status_q[HWR_ST_PD] <= 1'b1;
      end
      else if (wdt_run_rst)
        status_q[HWR_ST_TO] <= 1'b1;                            // R20
      else if (pin_fall & halted)
      begin
        status_q[HWR_ST_TO] <= 1'b0;                            // R15
        status_q[HWR_ST_PD] <= 1'b1;
      end
      else if (clrw_cmd)
      begin
        status_q[HWR_ST_PD] <= 1'b0;                            // R7
        status_q[HWR_ST_TO] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // special registers; writes blocked while halted
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdsel_q <= HWR_RST_WDSEL;                                 // R18
      interrupt_control_q  <= HWR_RST_INTERRUPT_CONTROL;
      t0c_q   <= HWR_RST_TC;
      t1c_q   <= HWR_RST_TC;
      pad_q   <= HWR_RST_PORT;
      padir_q <= HWR_RST_PORT;
      pbd_q   <= HWR_RST_PORT;
      pbdir_q <= HWR_RST_PORT;
      pfd_q   <= HWR_RST_2B;
      dacc_q  <= HWR_RST_2B;
      chsel_q <= HWR_RST_CHSEL;
    end
    // voice channel select keeps its value here; only power-up clears it
    else if (full_rst)
    begin
      wdsel_q <= HWR_RST_WDSEL;                                 // R18
      interrupt_control_q  <= HWR_RST_INTERRUPT_CONTROL;                                  // R17
      t0c_q   <= HWR_RST_TC;
      t1c_q   <= HWR_RST_TC;
      pad_q   <= HWR_RST_PORT;
      padir_q <= HWR_RST_PORT;                                  // R17
      pbd_q   <= HWR_RST_PORT;
      pbdir_q <= HWR_RST_PORT;
      pfd_q   <= HWR_RST_2B;
      dacc_q  <= HWR_RST_2B;
    end
    else if (wdt_wake)
    begin
      t0c_q[HWR_TC_FORCE] <= 1'b1;                              // R19
      t1c_q[HWR_TC_FORCE] <= 1'b1;
    end
    else
    begin
      interrupt_control_q <= set_irq_flags(interrupt_control_q, irq_event);
      if (wr & ~halted)                                         // R2
      begin
        if (hit(HWR_OFF_WDSEL)) wdsel_q <= apb_req.pwdata[7:0];
        if (hit(HWR_OFF_INTERRUPT_CONTROL))
          interrupt_control_q <= set_irq_flags(apb_req.pwdata[7:0] & HWR_INTERRUPT_CONTROL_MASK, irq_event);
        if (hit(HWR_OFF_T0C))   t0c_q   <= apb_req.pwdata[7:0];
        if (hit(HWR_OFF_T1C))   t1c_q   <= apb_req.pwdata[7:0];
        if (hit(HWR_OFF_PAD))   pad_q   <= apb_req.pwdata[7:0];
        if (hit(HWR_OFF_PADIR)) padir_q <= apb_req.pwdata[7:0];
        if (hit(HWR_OFF_PBD))   pbd_q   <= apb_req.pwdata[7:0];
        if (hit(HWR_OFF_PBDIR)) pbdir_q <= apb_req.pwdata[7:0];
        if (hit(HWR_OFF_PFD))   pfd_q   <= apb_req.pwdata[1:0];
        if (hit(HWR_OFF_DACC))  dacc_q  <= apb_req.pwdata[1:0];
        if (hit(HWR_OFF_CHSEL)) chsel_q <= apb_req.pwdata[3:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // outputs toward core and watchdog
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_clear      <= 1'b1;
      pc_sp_reset    <= 1'b1;
      chip_reset     <= 1'b1;
      irq_vector_req <= 1'b0;
    end
    else
    begin
      wdt_clear      <= halt_cmd | full_rst | clrw_cmd;         // R3
      pc_sp_reset    <= full_rst | wdt_wake;                    // R8
      chip_reset     <= full_rst;                               // R17
      irq_vector_req <= (state_q == HWR_IACK);                  // R13
    end
  end

  assign halt_out   = halted;                                   // R5
  assign cpu_stop_o = (state_q != HWR_RUN);                     // R1
  // a one in the direction register means input, so drive only on zero
  assign port_a_oe  = ~padir_q;                                 // R2
  assign port_b_oe  = ~pbdir_q;

  // ---------------------------------------------------------------------------
  // apb read path, zero wait states
  // ---------------------------------------------------------------------------
  always_comb
  begin
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = 1'b0;
    apb_rsp.prdata  = '0;
    if (rd)
    begin
      case (apb_req.paddr)
        HWR_OFF_WDSEL:  apb_rsp.prdata[7:0] = wdsel_q;
        HWR_OFF_STATUS: apb_rsp.prdata[5:0] = status_q;
        HWR_OFF_INTERRUPT_CONTROL:   apb_rsp.prdata[7:0] = interrupt_control_q & HWR_INTERRUPT_CONTROL_MASK;
        HWR_OFF_T0C:    apb_rsp.prdata[7:0] = t0c_q;
        HWR_OFF_T1C:    apb_rsp.prdata[7:0] = t1c_q;
        HWR_OFF_PAD:    apb_rsp.prdata[7:0] = pad_q;
        HWR_OFF_PADIR:  apb_rsp.prdata[7:0] = padir_q;
        HWR_OFF_PBD:    apb_rsp.prdata[7:0] = pbd_q;
        HWR_OFF_PBDIR:  apb_rsp.prdata[7:0] = pbdir_q;
        HWR_OFF_PFD:    apb_rsp.prdata[1:0] = pfd_q;
        HWR_OFF_DACC:   apb_rsp.prdata[1:0] = dacc_q;
        HWR_OFF_CHSEL:  apb_rsp.prdata[3:0] = chsel_q;
        HWR_OFF_CMD:    apb_rsp.prdata      = '0;
        HWR_OFF_CPU:    apb_rsp.prdata[3:0] = state_q;
        default:        apb_rsp.pslverr     = apb_req.penable;
      endcase
    end
    else if (apb_req.psel & ~hit(HWR_OFF_CMD) & ~(apb_req.paddr <= HWR_OFF_CHSEL & apb_req.paddr[1:0] == 2'b00))
      apb_rsp.pslverr = apb_req.penable;
  end

endmodule // hwr_ctrl
`default_nettype wire

/* dv/hwr_ctrl_assertions.sv */
// Purpose: port-level checks of halt, wake-up and reset control
// Assumes: one clock domain, presetn async active low
// Notes:   bound into hwr_ctrl
`timescale 1ns/1ps
`default_nettype none
module hwr_ctrl_assertions
  import hwr_pkg::*;
#(
  parameter int STARTUP_CYCLES = HWR_STARTUP_TSYS
)(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire hwr_apb_req_t apb_req,
  input wire logic         external_reset_pin_n,
  input wire logic         wdt_overflow,
  input wire logic         stack_full,
  input wire logic         wdt_clear,
  input wire logic         halt_out,
  input wire logic         cpu_stop_o,
  input wire logic         pc_sp_reset,
  input wire logic         chip_reset,
  input wire logic         irq_vector_req,
  input wire logic [7:0]   port_a_oe,
  input wire logic [7:0]   port_b_oe
);
  localparam int LO = STARTUP_CYCLES - 2;
  localparam int HI = STARTUP_CYCLES + 2;
  logic        halt_cmd;
  logic [15:0] stop_cnt_q;
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  assign halt_cmd = apb_req.psel && apb_req.penable && apb_req.pwrite && !cpu_stop_o
                    && apb_req.paddr == HWR_OFF_CMD && apb_req.pwdata[HWR_CMD_HALT];
  // cycles spent stopped outside halt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stop_cnt_q <= 16'h0000;
    else if (cpu_stop_o && !halt_out)
      stop_cnt_q <= stop_cnt_q + 16'h0001;
    else
      stop_cnt_q <= 16'h0000;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_halt_out_rise: assert property (halt_cmd |=> halt_out)
    else $error("halt output not raised");
  a_halt_wdt_clr: assert property (halt_cmd |=> wdt_clear)
    else $error("watchdog not cleared on halt");
  a_halt_clk_stop: assert property (halt_out |-> cpu_stop_o)
    else $error("clock running while halted");
  a_halt_oe_held: assert property (halt_out && $past(halt_out) |-> $stable(port_a_oe) && $stable(port_b_oe))
    else $error("port drive changed in halt");
  a_wake_to_delay: assert property (halt_out && wdt_overflow |=> !halt_out && cpu_stop_o)
    else $error("no delay after wake");
  a_warm_pc_only: assert property (halt_out && wdt_overflow |-> ##[1:2] pc_sp_reset && !chip_reset)
    else $error("warm reset wrong");
  a_delay_length: assert property ($fell(cpu_stop_o) && !$past(halt_out) |-> stop_cnt_q inside {[LO:HI]})
    else $error("start-up delay length wrong");
  a_pin_reset: assert property ($fell(external_reset_pin_n) |-> ##[1:3] chip_reset)
    else $error("pin reset missing");
  a_run_wdt_full: assert property (!cpu_stop_o && wdt_overflow |-> ##[1:2] chip_reset)
    else $error("run watchdog reset missing");
  a_vector_cause: assert property ($rose(irq_vector_req) |-> $past(cpu_stop_o) && !stack_full)
    else $error("vector request out of place");
  a_oe_cleared: assert property (chip_reset |-> ##[0:1] (port_a_oe == 8'h00 && port_b_oe == 8'h00))
    else $error("ports not input after reset");
endmodule // hwr_ctrl_assertions
bind hwr_ctrl hwr_ctrl_assertions #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_hwr_ctrl_assertions (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .external_reset_pin_n(external_reset_pin_n),
  .wdt_overflow(wdt_overflow), .stack_full(stack_full), .wdt_clear(wdt_clear), .halt_out(halt_out),
  .cpu_stop_o(cpu_stop_o), .pc_sp_reset(pc_sp_reset), .chip_reset(chip_reset),
  .irq_vector_req(irq_vector_req), .port_a_oe(port_a_oe), .port_b_oe(port_b_oe));
`default_nettype wire

/* dv/hwr_far_model.sv */
// Purpose: reset pin, port a lines and watchdog seen from outside
// Assumes: reset pin and port a pulled high when not driven low
// Notes:   one event per pulse call
`timescale 1ns/1ps
`default_nettype none
module hwr_far_model (
  input  wire logic  pclk,
  output logic       rst_pin_n,
  output logic [7:0] pa_pins,
  output logic       wdt_ovf
);
  initial
  begin
    rst_pin_n = 1'b1;
    pa_pins   = 8'hFF;
    wdt_ovf   = 1'b0;
  end
  // kind 0 pin reset, 1 port a fall on mask, 2 watchdog overflow
  task automatic pulse(input logic [1:0] kind, input logic [7:0] mask);
    @(posedge pclk);
    rst_pin_n <= (kind != 2'd0);
    pa_pins   <= (kind == 2'd1) ? ~mask : 8'hFF;
    wdt_ovf   <= (kind == 2'd2);
    @(posedge pclk);
    rst_pin_n <= 1'b1;
    pa_pins   <= 8'hFF;
    wdt_ovf   <= 1'b0;
    @(negedge pclk);
  endtask
endmodule // hwr_far_model
`default_nettype wire

/* dv/halt_wakeup_reset_control_tb.sv */
// Purpose: self-checking bench for hwr_ctrl
// Assumes: zero-wait apb, short start-up count
// Notes:   random register values from a fixed-seed lfsr
`timescale 1ns/1ps
`default_nettype none
module halt_wakeup_reset_control_tb;
  import hwr_pkg::*;
  localparam logic [7:0] ROFF [12] = '{HWR_OFF_WDSEL, HWR_OFF_INTERRUPT_CONTROL, HWR_OFF_T0C, HWR_OFF_T1C, HWR_OFF_PAD,
    HWR_OFF_PADIR, HWR_OFF_PBD, HWR_OFF_PBDIR, HWR_OFF_PFD, HWR_OFF_DACC, HWR_OFF_CHSEL, HWR_OFF_CMD};
  localparam logic [7:0] RVAL [12] = '{8'h07, 8'h00, 8'h08, 8'h08, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00,
    8'h00, 8'h00};
  logic         pclk, presetn, pin_n, wdt_ovf, stk, vec, er;
  logic [1:0]   irq;
  logic [7:0]   pa, aoe, boe, wd, tc, pv, dir;
  logic [15:0]  r;
  logic [31:0]  rd;
  hwr_apb_req_t req;
  hwr_apb_rsp_t rsp;
  wire          halt_out, cpu_stop_o, irq_vector_req;
  int           err_count, tests_run, cyc;
  hwr_ctrl #(.STARTUP_CYCLES(16), .PA_WAKE_OPTION(8'hFE)) u_hwr_ctrl (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .external_reset_pin_n(pin_n), .port_a_pins(pa), .wdt_overflow(wdt_ovf),
    .irq_event(irq), .stack_full(stk), .wdt_clear(), .halt_out(halt_out), .cpu_stop_o(cpu_stop_o),
    .pc_sp_reset(), .chip_reset(), .irq_vector_req(irq_vector_req), .port_a_oe(aoe), .port_b_oe(boe));
  hwr_far_model u_hwr_far_model (.pclk(pclk), .rst_pin_n(pin_n), .pa_pins(pa), .wdt_ovf(wdt_ovf));
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic final_report();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1)
      @(posedge pclk);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(negedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd & m, exp & m);
  endtask
  task automatic halt();
    xfer(1'b1, HWR_OFF_CMD, 32'h0000_0001);
    chk({31'h0, halt_out}, 32'h0000_0001);
  endtask
  task automatic irq_pulse(input logic [1:0] m);
    @(posedge pclk);
    irq <= m;
    @(posedge pclk);
    irq <= 2'b00;
    @(negedge pclk);
  endtask
  task automatic wait_run();
    vec = 1'b0;
    for (int i = 0; i < 64 && cpu_stop_o !== 1'b0; i++)
      @(negedge pclk) vec |= (irq_vector_req === 1'b1);
    repeat (3) @(negedge pclk) vec |= (irq_vector_req === 1'b1);
    chk({31'h0, cpu_stop_o}, 32'h0000_0000);
  endtask
  // ---------------------------------------------------------------------------
  // clock, timeout and sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  initial
  begin
    presetn = 1'b0;
    req = '0;
    irq = 2'b00;
    stk = 1'b0;
    r = 16'h2361;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++)
      rdc(ROFF[i], {24'h0, RVAL[i]}, 32'h0000_00FF);
    rdc(HWR_OFF_STATUS, 32'h0000_0000, 32'h0000_0030);
    chk({16'h0, aoe, boe}, 32'h0000_0000);
    wait_run();
    r = lfsr(r);
    {wd, tc} = r;
    r = lfsr(r);
    {pv, dir} = r;
    xfer(1'b1, HWR_OFF_WDSEL, {24'h0, wd});
    xfer(1'b1, HWR_OFF_T0C, {24'h0, tc});
    xfer(1'b1, HWR_OFF_PAD, {24'h0, pv});
    xfer(1'b1, HWR_OFF_PADIR, {24'h0, dir});
    chk({24'h0, aoe}, {24'h0, ~dir});
    halt();
    rdc(HWR_OFF_STATUS, 32'h0000_0010, 32'h0000_0030);
    xfer(1'b1, HWR_OFF_WDSEL, {24'h0, ~wd});
    u_hwr_far_model.pulse(2'd1, 8'h01);
    repeat (4) @(negedge pclk);
    chk({31'h0, halt_out}, 32'h0000_0001);
    u_hwr_far_model.pulse(2'd2, 8'h00);
    wait_run();
    chk({31'h0, vec}, 32'h0000_0000);
    rdc(HWR_OFF_WDSEL, {24'h0, wd}, 32'h0000_00FF);
    rdc(HWR_OFF_T0C, {24'h0, tc | 8'h08}, 32'h0000_00FF);
    rdc(HWR_OFF_PAD, {24'h0, pv}, 32'h0000_00FF);
    rdc(HWR_OFF_STATUS, 32'h0000_0030, 32'h0000_0030);
    xfer(1'b1, HWR_OFF_CMD, 32'h0000_0002);
    rdc(HWR_OFF_STATUS, 32'h0000_0000, 32'h0000_0030);
    xfer(1'b1, HWR_OFF_INTERRUPT_CONTROL, 32'h0000_0005);
    irq_pulse(2'b10);
    rdc(HWR_OFF_INTERRUPT_CONTROL, 32'h0000_0045, 32'h0000_00FF);
    halt();
    irq_pulse(2'b10);
    repeat (4) @(negedge pclk);
    chk({31'h0, halt_out}, 32'h0000_0001);
    irq_pulse(2'b01);
    wait_run();
    chk({31'h0, vec}, 32'h0000_0001);
    xfer(1'b1, HWR_OFF_INTERRUPT_CONTROL, 32'h0000_0005);
    @(posedge pclk) stk <= 1'b1;
    halt();
    irq_pulse(2'b01);
    wait_run();
    chk({31'h0, vec}, 32'h0000_0000);
    @(posedge pclk) stk <= 1'b0;
    xfer(1'b1, HWR_OFF_INTERRUPT_CONTROL, 32'h0000_0000);
    halt();
    u_hwr_far_model.pulse(2'd1, 8'h02);
    wait_run();
    chk({31'h0, vec}, 32'h0000_0000);
    r = lfsr(r);
    xfer(1'b1, HWR_OFF_WDSEL, {16'h0, r});
    halt();
    u_hwr_far_model.pulse(2'd0, 8'h00);
    repeat (3) @(negedge pclk);
    chk({31'h0, cpu_stop_o}, 32'h0000_0000);
    rdc(HWR_OFF_WDSEL, 32'h0000_0007, 32'h0000_00FF);
    rdc(HWR_OFF_STATUS, 32'h0000_0010, 32'h0000_0030);
    xfer(1'b1, HWR_OFF_PADIR, 32'h0000_0000);
    u_hwr_far_model.pulse(2'd2, 8'h00);
    repeat (3) @(negedge pclk);
    rdc(HWR_OFF_PADIR, 32'h0000_00FF, 32'h0000_00FF);
    rdc(HWR_OFF_STATUS, 32'h0000_0030, 32'h0000_0030);
    u_hwr_far_model.pulse(2'd0, 8'h00);
    repeat (3) @(negedge pclk);
    rdc(HWR_OFF_STATUS, 32'h0000_0030, 32'h0000_0030);
    xfer(1'b0, 8'h38, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    final_report();
  end
endmodule // halt_wakeup_reset_control_tb
`default_nettype wire
